//--- rtl/reset_boot_clock_startup.v
// Purpose: start-up sequencing: straps, lock wait, reset vector start, shared reset pin
// Assumes: APB slave on pclk; straps and running reset pin are asynchronous
// Notes:   pready is always high, so every transfer completes in its first access cycle
//          the status word shows the live lock count, so software can poll the wait
//          pull-ups come up enabled so memory selects idle high before software runs
//          the shared pin is released only by software; the board must pull it high
//
// Functional notes
// - after reset release wait exactly 4096 input clocks, core held idle
// - after the lock wait, start fetching at the fixed reset vector
// - initial core clock ratio comes from the two clock-ratio straps
// - once running, software may rewrite PLL multiplier and divider anytime
// - shared reset pin is a reset output by default
// - setting bit 0 of running reset control makes the pin a running-reset input
// - software switches memory-select pull-ups on or off; strength fixed
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "startup_defines.vh"
module reset_boot_clock_startup (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [1:0]  clk_cfg,
   input  wire [1:0]  boot_cfg,
   input  wire        reset_output_pin_in_n,
   output wire        reset_output_pin_out_n,
   output wire        reset_output_pin_oe,
   output reg         core_run,
   output reg         core_fetch_start,
   output reg  [31:0] core_fetch_addr,
   output reg  [1:0]  boot_mode,
   output reg  [5:0]  pll_multiplier,
   output reg  [1:0]  pll_divider,
   output reg         memory_select_two_pullup_en,
   output reg         memory_select_three_pullup_en
);
   localparam ST_LOCK = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_HOLD = 2'h2;

   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [12:0] lock_count;
   reg         run_reset_enable;
   reg  [1:0]  clk_ratio;
   wire [1:0]  clk_cfg_sync;
   wire [1:0]  boot_cfg_sync;
   wire        running_reset_input_n;
   wire        setup_phase;
   wire        write_access;
   wire        addr_mapped;
   reg  [5:0]  strap_mult;
   wire        lock_done;
   wire        strap_capture;
   wire        hold_request;
   wire        pm_write;
   wire        rr_write;
   wire        pu_write;
   wire [31:0] power_mode_word;
   wire [31:0] run_reset_word;
   wire [31:0] pullup_word;
   wire [31:0] status_word;
   reg  [31:0] read_word;

   // straps and the shared pin come from the board, so they are synchronised first
   sync_two_ff #(.WIDTH(4)) u_strap_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({clk_cfg, boot_cfg}),
      .sync_out ({clk_cfg_sync, boot_cfg_sync})
   );

   sync_two_ff #(.WIDTH(1)) u_pin_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (reset_output_pin_in_n),
      .sync_out (running_reset_input_n)
   );

   // strap code to start-up multiplier
   always @* begin
      case (clk_cfg_sync)
         2'h0:    strap_mult = `RATIO0_MULT;
         2'h1:    strap_mult = `RATIO1_MULT;
         2'h2:    strap_mult = `RATIO2_MULT;
         default: strap_mult = `RATIO3_MULT;
      endcase
   end

   // sequencer milestones; the strap capture point is shared by two processes
   assign lock_done     = (lock_count == `LOCK_LAST);
   assign strap_capture = (state == ST_LOCK) && (lock_count == `STRAP_SAMPLE);
   assign hold_request  = run_reset_enable && !running_reset_input_n;

   // sequencer: lock wait, run, and hold while a running reset is applied
   always @* begin
      next_state = state;
      case (state)
         ST_LOCK: begin
            if (lock_done)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            if (hold_request)
               next_state = ST_HOLD;
         end
         ST_HOLD: begin
            // no relock needed: the input clock never stopped
            if (!hold_request)
               next_state = ST_RUN;
         end
         default: next_state = ST_LOCK;
      endcase
   end

   // the lock counter starts at the release edge; presetn itself is the hold, on board
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state            <= ST_LOCK;
         lock_count       <= 13'h0000;
         core_run         <= 1'b0;
         core_fetch_start <= 1'b0;
         core_fetch_addr  <= 32'h0000_0000;
      end else begin
         state            <= next_state;
         core_run         <= (next_state == ST_RUN); // core idle until lock ends
         core_fetch_start <= (next_state == ST_RUN) && (state != ST_RUN);
         core_fetch_addr  <= `RESET_VECTOR;
         if (state == ST_LOCK)
            lock_count <= lock_count + 13'h0001;
      end
   end

   // straps are caught once the synchronisers have filled after release
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_mode <= 2'h0;
         clk_ratio <= 2'h0;
      end else if (strap_capture) begin
         boot_mode <= boot_cfg_sync; // valid levels assumed before reset
         clk_ratio <= clk_cfg_sync;
      end
   end

   // shared pin: drives reset low during lock wait, released to input on request
   assign reset_output_pin_oe    = !run_reset_enable;
   assign reset_output_pin_out_n = (state != ST_LOCK);

   // apb decode: setup phase latches read data, access phase commits writes
   assign pready       = 1'b1;
   assign setup_phase  = psel && !penable;
   assign write_access = psel && penable && pwrite;
   assign addr_mapped  = (paddr == `OFS_POWER_MODE) || (paddr == `OFS_RUN_RESET) ||
                         (paddr == `OFS_PULLUP) || (paddr == `OFS_STATUS);
   assign pslverr      = psel && penable && !addr_mapped;
   assign pm_write     = write_access && (paddr == `OFS_POWER_MODE) && (state != ST_LOCK);
   assign rr_write     = write_access && (paddr == `OFS_RUN_RESET);
   assign pu_write     = write_access && (paddr == `OFS_PULLUP);

   // readback words; reserved bits read as zero
   assign power_mode_word = {22'h000000, pll_divider, 2'h0, pll_multiplier};
   assign run_reset_word  = {31'h00000000, run_reset_enable};
   assign pullup_word     = {30'h00000000, memory_select_three_pullup_en,
                             memory_select_two_pullup_en};
   assign status_word     = {11'h000, lock_count, clk_ratio, boot_mode,
                             running_reset_input_n, core_run, state};

   // control registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_multiplier                <= `RATIO0_MULT;
         pll_divider                   <= `RATIO_DIV;
         run_reset_enable              <= 1'b0; // reset output by default
         memory_select_two_pullup_en   <= 1'b1;
         memory_select_three_pullup_en <= 1'b1;
      end else begin
         if (strap_capture) begin
            pll_multiplier <= strap_mult; // start-up ratio from straps
            pll_divider    <= `RATIO_DIV;
         end else if (pm_write) begin
            // writes during the lock wait are dropped: the straps own the ratio then
            pll_multiplier <= pwdata[`PM_MULT_MSB:`PM_MULT_LSB];
            pll_divider    <= pwdata[`PM_DIV_MSB:`PM_DIV_LSB];
         end
         if (rr_write)
            run_reset_enable <= pwdata[`RR_ENABLE_BIT];
         if (pu_write) begin
            memory_select_two_pullup_en   <= pwdata[`PU_MS2_BIT];
            memory_select_three_pullup_en <= pwdata[`PU_MS3_BIT];
         end
      end
   end

   // read mux kept combinational; the register below gives a stable prdata
   always @* begin
      case (paddr)
         `OFS_POWER_MODE: read_word = power_mode_word;
         `OFS_RUN_RESET:  read_word = run_reset_word;
         `OFS_PULLUP:     read_word = pullup_word;
         `OFS_STATUS:     read_word = status_word;
         default:         read_word = 32'h0000_0000; // unmapped reads return zero
      endcase
   end

   // read data registered in the setup phase, stable through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata <= read_word;
      end
   end
endmodule // reset_boot_clock_startup

//--- rtl/startup_defines.vh
// Purpose: constants for the start-up sequencer and its register map
// Assumes: 40 MHz pclk, which is also the input clock of the part
// Notes:   definitions only
`ifndef STARTUP_DEFINES_VH
`define STARTUP_DEFINES_VH

// register byte offsets
`define OFS_POWER_MODE     8'h00
`define OFS_RUN_RESET      8'h04
`define OFS_PULLUP         8'h08
`define OFS_STATUS         8'h0C

// power mode control fields
`define PM_MULT_LSB        0
`define PM_MULT_MSB        5
`define PM_DIV_LSB         8
`define PM_DIV_MSB         9

// running reset control and pull-up control bits
`define RR_ENABLE_BIT      0
`define PU_MS2_BIT         0
`define PU_MS3_BIT         1

// lock latency in input-clock cycles, and strap sampling point
`define LOCK_CYCLES        13'd4096
`define LOCK_LAST          13'd4095
`define STRAP_SAMPLE       13'd2

// start-up multiplier / divider per clock-ratio strap code
`define RATIO0_MULT        6'h08
`define RATIO1_MULT        6'h20
`define RATIO2_MULT        6'h10
`define RATIO3_MULT        6'h08
`define RATIO_DIV          2'h0

// fixed hardware reset vector
`define RESET_VECTOR       32'h0009_0000

`endif

//--- rtl/sync_two_ff.v
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: input is a slow level from outside the pclk domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module sync_two_ff #(
   parameter WIDTH = 1
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;

   // both stages reset to a constant; meta is read only by the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta     <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule // sync_two_ff

//--- verif/startup_checker.sv
// Purpose: port assertions for the start-up sequencer
// Assumes: one pclk domain, presetn async active low
// Notes:   cnt counts edges since reset release and saturates
`timescale 1ns/100ps
`include "startup_defines.vh"
module startup_checker (
   input wire        pclk,
   input wire        presetn,
   input wire [7:0]  paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire        reset_output_pin_oe,
   input wire        reset_output_pin_out_n,
   input wire        core_run,
   input wire        core_fetch_start,
   input wire [31:0] core_fetch_addr,
   input wire [5:0]  pll_multiplier,
   input wire        memory_select_two_pullup_en,
   input wire        memory_select_three_pullup_en
);
   logic [12:0] cnt;
   wire         wr = psel && penable && pwrite;
   wire         b0 = pwdata[0];
   wire  [1:0]  u  = pwdata[1:0];
   wire  [5:0]  m  = pwdata[5:0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // saturate so the lock window is never seen twice in one run
   always @(posedge pclk or negedge presetn)
      if (!presetn) cnt <= 13'h0;
      else if (cnt != 13'h1001) cnt <= cnt + 13'h1;
   property p_lock_idle; cnt < 13'h1000 |-> !core_run && !reset_output_pin_out_n; endproperty
   a_lock_idle: assert property (p_lock_idle) else $error("core ran in lock wait");
   property p_lock_end; cnt == 13'h1000 |-> core_run && core_fetch_start; endproperty
   a_lock_end: assert property (p_lock_end) else $error("core late after lock");
   property p_vector; core_fetch_start |-> core_fetch_addr == `RESET_VECTOR; endproperty
   a_vector: assert property (p_vector) else $error("bad start address");
   property p_pulse; core_fetch_start |=> !core_fetch_start; endproperty
   a_pulse: assert property (p_pulse) else $error("start pulse too long");
   property p_restart; $rose(core_run) |-> core_fetch_start; endproperty
   a_restart: assert property (p_restart) else $error("run without start");
   property p_oe; wr && paddr == `OFS_RUN_RESET |=> reset_output_pin_oe == !$past(b0); endproperty
   a_oe: assert property (p_oe) else $error("pin direction wrong");
   property p_pll; wr && paddr == `OFS_POWER_MODE && core_run |=> pll_multiplier == $past(m);
   endproperty
   a_pll: assert property (p_pll) else $error("multiplier not taken");
   property p_pll_lock; wr && paddr == `OFS_POWER_MODE && cnt > 13'h8 && cnt < 13'h1000
      |=> $stable(pll_multiplier); endproperty
   a_pll_lock: assert property (p_pll_lock) else $error("multiplier moved in lock");
   property p_pullup; wr && paddr == `OFS_PULLUP
      |=> {memory_select_three_pullup_en, memory_select_two_pullup_en} == $past(u); endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up not taken");
endmodule // startup_checker
bind reset_boot_clock_startup startup_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable,
   .pwrite, .pwdata, .reset_output_pin_oe, .reset_output_pin_out_n, .core_run,
   .core_fetch_start, .core_fetch_addr, .pll_multiplier, .memory_select_two_pullup_en,
   .memory_select_three_pullup_en);

//--- verif/board_model.sv
// Purpose: board side of the shared reset pin
// Assumes: pin has a pull-up on the board
// Notes:   a released pin reads high unless the board pulls it
`timescale 1ns/100ps
module board_model (
   input  wire pin_oe,
   input  wire pin_out_n,
   input  wire pull_low,
   output wire pin_in_n
);
   // resolve the wire from both drivers
   assign pin_in_n = pin_oe ? pin_out_n : !pull_low;
endmodule // board_model

//--- verif/tb_reset_boot_clock_startup.sv
// Purpose: self-checking bench for the start-up sequencer
// Assumes: 40 MHz pclk, APB answers when pready is high
// Notes:   full 4096-cycle lock wait per strap code
`timescale 1ns/100ps
`include "startup_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_reset_boot_clock_startup;
   logic        pclk, presetn, psel, penable, pwrite, pull_low;
   logic [7:0]  paddr;
   logic [31:0] pwdata, seed, r;
   logic [1:0]  clk_cfg, boot_cfg;
   logic [32:0] q[$], e;
   wire  [31:0] prdata, fa;
   wire  [5:0]  mult;
   wire  [1:0]  boot_mode, div;
   wire         pready, pslverr, pin_in, pin_out, pin_oe, core_run, fs, pu2, pu3;
   int          err_count, tests_run, n, k, t0, cyc;
   logic [5:0]  ratio [0:3] = '{`RATIO0_MULT, `RATIO1_MULT, `RATIO2_MULT, `RATIO3_MULT};
   reset_boot_clock_startup dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .clk_cfg, .boot_cfg, .reset_output_pin_in_n(pin_in),
      .reset_output_pin_out_n(pin_out), .reset_output_pin_oe(pin_oe), .core_run,
      .core_fetch_start(fs), .core_fetch_addr(fa), .boot_mode, .pll_multiplier(mult),
      .pll_divider(div), .memory_select_two_pullup_en(pu2), .memory_select_three_pullup_en(pu3));
   board_model board (.pin_oe, .pin_out_n(pin_out), .pull_low, .pin_in_n(pin_in));
   function logic [31:0] xs();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction
   task test_done;
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one transfer; an idle edge after it keeps drivers from double assignment
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
      if (!w) q.push_back(x);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk); while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   initial begin pclk = 0; forever #12.5 pclk = ~pclk; end
   always @(posedge pclk) cyc <= cyc + 1;
   // read data is judged at the access edge against the oldest note
   always @(posedge pclk) if (psel && penable && !pwrite && pready) begin
      e = q.pop_front(); `CHK({pslverr, prdata}, e)
   end
   initial begin #1000000; err_count++; test_done; end
   initial begin
      {presetn, psel, penable, pwrite, pull_low, paddr, pwdata, clk_cfg, boot_cfg} = '0;
      seed = 32'h6;
      for (k = 0; k < 4; k++) begin
         r = xs();
         // straps settle while reset is held low
         presetn <= 1'b0; clk_cfg <= k[1:0]; boot_cfg <= r[1:0];
         repeat (20) @(posedge pclk);
         presetn <= 1'b1;
         #1 t0 = cyc;
         // past the strap capture edge, so only the lock-wait refusal can drop it
         repeat (10) @(posedge pclk);
         apb(1'b1, `OFS_POWER_MODE, 32'h3F, 33'h0); // too early, must be dropped
         n = 0; while (core_run !== 1'b1 && n < 5000) begin @(posedge pclk); #1 n++; end
         `CHK(cyc - t0, 4096)
         `CHK({fs, fa}, {1'b1, 32'h0009_0000})
         `CHK({mult, boot_mode}, {ratio[k], r[1:0]})
         `CHK({pin_oe, pin_out}, 2'h3)
         @(posedge pclk);
      end
      // let the released pin level cross its synchroniser before the status snapshot
      repeat (4) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h0, {1'b0, 11'h000, `LOCK_CYCLES, 2'h3, r[1:0], 4'hD});
      for (k = 0; k < 4; k++) begin
         r = xs();
         apb(1'b1, `OFS_POWER_MODE, r, 33'h0);
         apb(1'b0, `OFS_POWER_MODE, 32'h0, {23'h0, r[9:8], 2'h0, r[5:0]});
         `CHK({div, mult}, {r[9:8], r[5:0]})
         apb(1'b1, `OFS_PULLUP, r, 33'h0);
         apb(1'b0, `OFS_PULLUP, 32'h0, {31'h0, r[1:0]});
         `CHK({pu3, pu2}, r[1:0])
      end
      apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
      apb(1'b0, `OFS_RUN_RESET, 32'h0, 33'h0);
      apb(1'b1, `OFS_RUN_RESET, 32'h1, 33'h0);
      `CHK(pin_oe, 1'b0)
      pull_low <= 1'b1;
      n = 0; while (core_run !== 1'b0 && n < 10) begin @(posedge pclk); n++; end
      `CHK(core_run, 1'b0)
      pull_low <= 1'b0;
      n = 0; while (fs !== 1'b1 && n < 10) begin @(posedge pclk); n++; end
      `CHK({fs, core_run, fa}, {1'b1, 1'b1, `RESET_VECTOR})
      apb(1'b1, `OFS_RUN_RESET, 32'h0, 33'h0);
      test_done;
   end
endmodule // tb_reset_boot_clock_startup
